// File: inc/adcsr_params.svh
/*
 constants for the pin-configured converter serial readout block.
 assumes a 10 MHz master clock; included by its bare name.
*/
`ifndef ADCSR_PARAMS_SVH
`define ADCSR_PARAMS_SVH

`define ADCSR_CLK_PERIOD_NS     100
`define ADCSR_WORD_BITS         24
`define ADCSR_HOST_GAP_CLKS     3
`define ADCSR_POS_FULL_SCALE    24'h7fffff
`define ADCSR_NEG_FULL_SCALE    24'h800000
`define ADCSR_RATE_BASE_CLKS    64
`define ADCSR_START_PW_CLKS     1

`endif

// File: inc/adcsr_pkg.sv
/*
 types for the converter serial readout block.
 assumes nothing beyond the params header.
*/
package adcsr_pkg;

    typedef enum logic [1:0] {
        ADCSR_IDLE  = 2'b00,
        ADCSR_CONV  = 2'b01,
        ADCSR_READY = 2'b10,
        ADCSR_SHIFT = 2'b11
    } adcsr_phase_t;

    typedef struct packed {
        logic       filter_path_sel;
        logic       low_latency_variant_sel;
        logic [1:0] data_rate_sel;
        logic       sclk_source_ext;
        logic       cmos_sel;
    } adcsr_cfg_t;

    typedef struct packed {
        logic dout_p;
        logic dout_n;
        logic dout_oe;
        logic rdy_p;
        logic rdy_n;
        logic sclk_p;
        logic sclk_p_oe;
        logic sclk_n;
        logic sclk_n_oe;
    } adcsr_link_t;

endpackage

// File: rtl/adcsr_readout.sv
/*
 control and serial result port of a 24-bit delta-sigma converter.
 assumes: one master clock, synchronous active-low reset, all pins
 except the master clock, reset and the filter core result come from outside and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adcsr_params.svh"

// Summary of operation
// - low latency pin picks settling or fast variant; here it is only copied to active_cfg and changes no timing
// - path pin picks wide-band or low-latency filter
// - start pin begins, resets and syncs conversion
// - chip select low enables readout
// - drive filter overrange flag output
// - internal shift clock drives both clock pins
// - external shift clock: negative pin tristated
// - positive clock pin direction follows source select
// - differential mode gives complementary data and ready
// - data advances after each shift clock rise
// - chip select high tristates data output
// - source select low internal, high external clock
// - interface pin low differential, high single-ended
// - power down low halts all activity
// - two's complement, saturating full-scale codes

module adcsr_readout
    import adcsr_pkg::*;
#(
    parameter int WORD_BITS      = `ADCSR_WORD_BITS,
    parameter int RATE_BASE_CLKS = `ADCSR_RATE_BASE_CLKS
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // configuration pins
    input  wire logic        filter_path_sel,
    input  wire logic        low_latency_variant_sel,
    input  wire logic [1:0]  data_rate_sel,
    input  wire logic        sclk_sel,
    input  wire logic        cmos_sel,
    input  wire logic        power_down_n,
    // conversion control
    input  wire logic        start,
    input  wire logic        cs_n,
    // result from the filter core
    input  wire logic [WORD_BITS-1:0] sample_in,
    input  wire logic        sample_overrange,
    // shift clock pin, positive side
    input  wire logic        sclk_p_in,
    // outputs
    output adcsr_link_t      link,
    output adcsr_cfg_t       active_cfg,
    output logic             result_ready_strobe,
    output logic             filter_overrange_flag,
    output logic             converting
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // the bit counter is five bits wide and the shifter fixed at 24
    if (WORD_BITS != 24)
    begin : g_bad_word
        $error("adcsr_readout: word width must be 24");
    end

    // slowest period is the base times sixteen, in sixteen bits
    if (RATE_BASE_CLKS < 8 || RATE_BASE_CLKS > 4095)
    begin : g_bad_rate
        $error("adcsr_readout: base period out of range");
    end

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    localparam int NS = 9;

    typedef struct packed {
        logic [NS-1:0]          s1;
        logic [NS-1:0]          s2;
        logic                   start_d;
        logic                   sclk_d;
        logic                   sclk_d2;
        adcsr_phase_t           phase;
        logic [15:0]            rate_cnt;
        logic [WORD_BITS-1:0]   shreg;
        logic [4:0]             bits_left;
        logic                   int_sclk;
        logic                   bit_now;
        logic                   rdy;
        logic                   otr;
        logic                   conv;
        adcsr_cfg_t             cfg;
    } adcsr_state_t;

    adcsr_state_t st;
    adcsr_state_t next_st;

    // order here must match the unpack in the next-state logic
    logic [NS-1:0] raw_pins;
    assign raw_pins = {filter_path_sel, low_latency_variant_sel,
                       data_rate_sel, sclk_sel, cmos_sel,
                       power_down_n, start, cs_n};

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // one-cycle rise from the present and the previous level
    function automatic logic rise
        (input logic now_lvl, input logic was_lvl);
        return now_lvl & ~was_lvl;
    endfunction

    // saturate the core result onto the full-scale codes
    function automatic logic [WORD_BITS-1:0] clamp
        (input logic [WORD_BITS-1:0] v, input logic ovr);
        logic [WORD_BITS-1:0] r;
        r = v;
        if (ovr)
            r = v[WORD_BITS-1] ? WORD_BITS'(`ADCSR_NEG_FULL_SCALE)
                               : WORD_BITS'(`ADCSR_POS_FULL_SCALE);
        return r;
    endfunction

    // conversion period: base doubled for each slower rate code
    function automatic logic [15:0] period
        (input logic [1:0] rate, input logic path);
        logic [15:0] p;
        p = 16'(RATE_BASE_CLKS) << (2'h3 - rate);
        if (path)
            p = 16'(p << 1);
        return p;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic       p_path;
    logic       p_ll;
    logic       p_ext;
    logic       p_cmos;
    logic       p_pd_n;
    logic       p_start;
    logic       p_cs_n;
    logic [1:0] p_rate;
    logic       sclk_s;
    logic       sclk_rise;
    logic       start_rise;
    logic       shift_ev;

    always_comb
    begin
        next_st = st;
        // --------------------------------------------------------
        // pin sampling
        // --------------------------------------------------------
        next_st.s1 = raw_pins;
        next_st.s2 = st.s1;
        // every pin below is the twice-sampled copy
        {p_path, p_ll, p_rate, p_ext, p_cmos, p_pd_n, p_start, p_cs_n}
            = st.s2;
        // shift clock pin gets its own two-stage sync
        next_st.sclk_d = sclk_p_in;
        next_st.sclk_d2 = st.sclk_d;
        sclk_s = st.sclk_d2;
        sclk_rise = 1'b0;
        start_rise = rise(p_start, st.start_d);
        next_st.start_d = p_start;
        next_st.cfg = '{filter_path_sel:         p_path,
                        low_latency_variant_sel: p_ll,
                        data_rate_sel:           p_rate,
                        sclk_source_ext:         p_ext,
                        cmos_sel:                p_cmos};
        next_st.rdy = 1'b0;
        // internal shift clock toggles every master clock in the shift phase, else held low
        next_st.int_sclk = (st.phase == ADCSR_SHIFT) ? ~st.int_sclk
                                                     : 1'b0;
        shift_ev = 1'b0;
        if (st.cfg.sclk_source_ext)
        begin
            // external clock sampled; rise found by edge compare
            sclk_rise = rise(sclk_s, st.bit_now);
            next_st.bit_now = sclk_s;
            shift_ev = sclk_rise;
        end
        else
        begin
            next_st.bit_now = 1'b0;
            shift_ev = st.int_sclk;
        end
        // --------------------------------------------------------
        // conversion sequencer
        // --------------------------------------------------------
        // wait for start, convert, flag ready, then shift out
        unique case (st.phase)
            ADCSR_IDLE:
            begin
                next_st.conv = 1'b0;
                if (start_rise)
                begin
                    next_st.phase = ADCSR_CONV;
                    next_st.rate_cnt = period(p_rate, p_path);
                    next_st.conv = 1'b1;
                end
            end
            ADCSR_CONV:
            begin
                next_st.rate_cnt = st.rate_cnt - 16'h0001;
                if (st.rate_cnt == 16'h0001)
                begin
                    next_st.shreg = clamp(sample_in, sample_overrange);
                    next_st.otr = sample_overrange;
                    next_st.rdy = 1'b1;
                    next_st.phase = ADCSR_READY;
                    next_st.bits_left = 5'(WORD_BITS);
                end
            end
            ADCSR_READY:
            begin
                // first bit already on the pin after ready
                next_st.phase = ADCSR_SHIFT;
                // ready cycle is counted, so one less keeps the pace
                next_st.rate_cnt = period(p_rate, p_path) - 16'h0001;
            end
            ADCSR_SHIFT:
            begin
                next_st.rate_cnt = st.rate_cnt - 16'h0001;
                // the host owes a quiet gap before the next ready
                if (shift_ev && st.bits_left > 5'h01 && !p_cs_n)
                begin
                    next_st.shreg = {st.shreg[WORD_BITS-2:0], 1'b0};
                    next_st.bits_left = st.bits_left - 5'h01;
                end
                if (st.rate_cnt <= 16'(`ADCSR_HOST_GAP_CLKS))
                    next_st.phase = ADCSR_CONV;
            end
        endcase
        // restart resyncs the conversion cycle at any time
        if (start_rise && st.phase != ADCSR_IDLE)
        begin
            next_st.phase = ADCSR_CONV;
            next_st.rate_cnt = period(p_rate, p_path);
            next_st.rdy = 1'b0;
        end
        // power down outranks start; a fresh start is needed after
        if (!p_pd_n)
        begin
            next_st.phase = ADCSR_IDLE;
            next_st.conv = 1'b0;
            next_st.otr = 1'b0;
            next_st.int_sclk = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            st <= '0;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // serial link pins
    // ------------------------------------------------------------
    logic diff;
    assign diff = ~st.cfg.cmos_sel;

    always_comb
    begin
        link.dout_p    = st.shreg[WORD_BITS-1];
        link.dout_n    = diff & ~st.shreg[WORD_BITS-1];
        // cs only passes the syncs, so tristate trails it two clocks
        link.dout_oe   = ~st.s2[0];
        link.rdy_p     = st.rdy;
        link.rdy_n     = diff & ~st.rdy;
        link.sclk_p    = st.int_sclk;
        link.sclk_p_oe = ~st.cfg.sclk_source_ext;
        link.sclk_n    = ~st.int_sclk;
        link.sclk_n_oe = ~st.cfg.sclk_source_ext;
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // flag holds until the next result lands or power down clears it
    assign active_cfg            = st.cfg;
    assign result_ready_strobe   = st.rdy;
    assign filter_overrange_flag = st.otr;
    assign converting            = st.conv;

endmodule
`default_nettype wire

// File: tb/adcsr_chk.sv
/* concurrent checks on the readout block ports.
 assumes binding into adcsr_readout; pins settle in 3 edges. */
`timescale 1ns/10ps
`default_nettype none
module adcsr_chk
    import adcsr_pkg::*;
(
    // watched ports
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        filter_path_sel,
    input wire logic        low_latency_variant_sel,
    input wire logic        sclk_sel,
    input wire logic        cmos_sel,
    input wire logic        power_down_n,
    input wire logic        cs_n,
    input wire adcsr_link_t link,
    input wire adcsr_cfg_t  active_cfg,
    input wire logic        result_ready_strobe,
    input wire logic        converting
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // five edges: syncs need three, margin for the edge detect
    sequence s_cs_off; cs_n [*5]; endsequence
    sequence s_pd; (!power_down_n) [*5]; endsequence
    a_ready_pulse: assert property (result_ready_strobe |=> !result_ready_strobe)
        else $error("ready pulse longer than one cycle");
    a_cs_off: assert property (s_cs_off |-> !link.dout_oe)
        else $error("data driven with chip select high");
    a_cs_on: assert property ((!cs_n) [*5] |-> link.dout_oe)
        else $error("data not driven with chip select low");
    a_sclk_int: assert property ((!sclk_sel && !cmos_sel) [*5] |->
        link.sclk_p_oe && link.sclk_n_oe && link.sclk_n != link.sclk_p)
        else $error("internal shift clock pair wrong");
    a_sclk_ext: assert property (sclk_sel [*5] |->
        !link.sclk_p_oe && !link.sclk_n_oe)
        else $error("shift clock pins driven in external mode");
    a_diff_pair: assert property ((!cmos_sel) [*5] |->
        link.dout_n != link.dout_p && link.rdy_n != link.rdy_p)
        else $error("pair not complementary");
    a_cmos_single: assert property (cmos_sel [*5] |->
        !link.dout_n && !link.rdy_n)
        else $error("negative pins active in single-ended mode");
    a_pdn_halt: assert property (s_pd |-> !converting && !result_ready_strobe)
        else $error("activity during power down");
    a_cfg_path: assert property ($stable(filter_path_sel) [*5] |->
        active_cfg.filter_path_sel == filter_path_sel)
        else $error("filter path not taken up");
    a_cfg_llv: assert property ($stable(low_latency_variant_sel) [*5] |->
        active_cfg.low_latency_variant_sel == low_latency_variant_sel)
        else $error("latency variant not taken up");
endmodule
`default_nettype wire

// File: tb/adcsr_host.sv
/* host model: captures 24 result bits, makes the external shift clock.
 assumes ready on link.rdy_p and a word period above 200 clocks. */
`timescale 1ns/10ps
`default_nettype none
module adcsr_host
    import adcsr_pkg::*;
(
    // clock and mode
    input  wire logic        clock,
    input  wire logic        ext,
    input  wire adcsr_link_t link,
    // shift clock and captured word
    output logic             sclk_p_in = 1'b0,
    output logic [23:0]      word
);
    int cnt = 24;
    int ph  = 0;
    // clock stands still outside frames
    always @(posedge clock)
    begin
        if (link.rdy_p)
        begin
            cnt <= 0;
            ph  <= 0;
        end
        else if (!ext && link.sclk_p && cnt < 24)
        begin
            word <= {word[22:0], link.dout_p};
            cnt  <= cnt + 1;
        end
        else if (ext && cnt < 24)
        begin
            ph <= ph + 1;
            if (ph % 8 == 3)
            begin
                word      <= {word[22:0], link.dout_p};
                sclk_p_in <= 1'b1;
            end
            if (ph % 8 == 7)
            begin
                sclk_p_in <= 1'b0;
                cnt       <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_adc_pin_config_serial_readout.sv
/* self-checking bench for the readout block.
 assumes host model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_adc_pin_config_serial_readout;
    import adcsr_pkg::*;
    localparam int RB = 32;
    logic        clock, rst_b, filter_path_sel, low_latency_variant_sel;
    logic        sclk_sel, cmos_sel, power_down_n, start, cs_n;
    logic        sample_overrange, result_ready_strobe, sclk_p_in;
    logic        filter_overrange_flag, converting;
    logic [1:0]  data_rate_sel;
    logic [23:0] sample_in, word;
    adcsr_link_t link;
    adcsr_cfg_t  active_cfg;
    int          n_fail = 0;
    int          checks = 0;
    adcsr_readout #(.RATE_BASE_CLKS(RB)) dut (.clock, .rst_b,
        .filter_path_sel, .low_latency_variant_sel, .data_rate_sel,
        .sclk_sel, .cmos_sel, .power_down_n, .start, .cs_n, .sample_in,
        .sample_overrange, .sclk_p_in, .link, .active_cfg,
        .result_ready_strobe, .filter_overrange_flag, .converting);
    adcsr_host host (.clock, .ext(sclk_sel), .link, .sclk_p_in, .word);
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp_w(input logic [23:0] g, e, input string m);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic wait_rdy(output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (result_ready_strobe !== 1'b1 && n < 3000);
    endtask
    // start held two clocks, set up four clocks early
    task automatic kick;
        repeat (4) @(posedge clock);
        start <= 1'b1;
        repeat (2) @(posedge clock);
        start <= 1'b0;
        // let the start pass the syncs before ready is watched
        repeat (3) @(posedge clock);
    endtask
    task automatic t_rate;
        int n;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clock);
            data_rate_sel <= 2'(k);
            filter_path_sel <= (k == 4);
            low_latency_variant_sel <= k[0];
            kick();
            wait_rdy(n);
            wait_rdy(n);
            cmp_w(24'(n), 24'((RB << (3 - k % 4)) << (k == 4)), "period");
        end
        $display("test rate done");
    endtask
    task automatic t_word(input logic ext, input logic [23:0] v,
                          input logic o, input logic [23:0] e);
        int n;
        @(posedge clock);
        sclk_sel <= ext;
        sample_in <= v;
        sample_overrange <= o;
        data_rate_sel <= 2'b00;
        filter_path_sel <= 1'b0;
        kick();
        wait_rdy(n);
        wait_rdy(n);
        cmp_w(word, e, "word");
        cmp_w(24'(filter_overrange_flag), 24'(o), "flag");
        $display("test word done");
    endtask
    task automatic t_pins;
        @(posedge clock);
        power_down_n <= 1'b0;
        cs_n <= 1'b1;
        repeat (6) @(posedge clock);
        cmp_w(24'(converting), 24'h0, "power down");
        cmp_w(24'(link.dout_oe), 24'h0, "cs high");
        power_down_n <= 1'b1;
        cs_n <= 1'b0;
        repeat (6) @(posedge clock);
        cmp_w(24'(link.dout_oe), 24'h1, "cs low");
        $display("test pins done");
    endtask
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        #3000000;
        n_fail++;
        final_report();
    end
    initial
    begin
        {rst_b, filter_path_sel, low_latency_variant_sel, sclk_sel} = 4'h0;
        {cmos_sel, start, cs_n, sample_overrange} = 4'h0;
        power_down_n = 1'b1;
        data_rate_sel = 2'b00;
        sample_in = 24'h0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        t_rate();
        t_word(1'b0, 24'h5a3c96, 1'b0, 24'h5a3c96);
        t_word(1'b1, 24'h81e7c3, 1'b0, 24'h81e7c3);
        cmos_sel <= 1'b1;
        t_word(1'b0, 24'h123456, 1'b1, 24'h7fffff);
        t_word(1'b0, 24'hedcba9, 1'b1, 24'h800000);
        t_pins();
        final_report();
    end
endmodule
bind adcsr_readout adcsr_chk chk (.clock, .rst_b, .filter_path_sel,
    .low_latency_variant_sel, .sclk_sel, .cmos_sel, .power_down_n, .cs_n,
    .link, .active_cfg, .result_ready_strobe, .converting);
`default_nettype wire
